// ### rtl/ecl_expo_lut.sv
// Behaviour
// - top bit reports exposure feature present
// - absolute select uses absolute register value
// - one-shot runs, self clears, reads busy
// - one-shot writes ignored in auto mode
// - enable bit switches feature, reads state
// - mode bit selects manual or auto
// - value writes dropped in auto or off
// - auto loop steers toward target within limits
// - higher target gives brighter image
// - auto loop is proportional plus integral
// - interlaced mode 1 minimum one field
// - sample addresses user table, byte output
// - table is 1024 by 8 bits
// - gamma is square root, upper 8 bits
// - gamma overrides user table
// - table contents are volatile
// - target confined to 50 through 205
module ecl_expo_lut
  import ecl_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // control bus register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_ack,
  // companion settings
  input wire logic [11:0] abs_value,
  input wire logic [7:0] target_level,
  input wire logic [11:0] limit_min,
  input wire logic [11:0] limit_max,
  input wire logic limit_use,
  input wire logic interlaced_mode1,
  input wire logic std_b,
  // table loading from the data exchange buffer
  input wire logic lut_wr,
  input wire logic [9:0] lut_wr_addr,
  input wire logic [7:0] lut_wr_data,
  input wire logic lut_enable,
  input wire logic gamma_enable,
  // pixel stream
  input wire logic pix_valid,
  input wire logic [9:0] pix_sample,
  output logic pix_out_valid,
  output logic [7:0] pix_out,
  // exposure brightness feedback, one pulse per frame
  input wire logic frame_done,
  input wire logic [7:0] frame_mean,
  // exposure to the sensor timing
  output logic [11:0] exposure_time
);
  // one whole field expressed in exposure steps
  localparam logic [11:0] FIELD_STEPS_A =
    12'((ECL_FIELD_MS_A * 1000) / 32'(ECL_US_PER_STEP));
  localparam logic [11:0] FIELD_STEPS_B =
    12'((ECL_FIELD_MS_B * 1000) / 32'(ECL_US_PER_STEP));

  typedef struct packed {
    logic abs_sel;
    logic once_busy;
    logic enable;
    logic auto_mode;
    logic [11:0] value;
    logic [15:0] integ;
    logic [7:0] once_cnt;
    logic [11:0] expo;
    logic [31:0] rdata;
    logic ack;
  } ecl_st_t;

  ecl_st_t st_r;
  ecl_st_t st_nxt;
  ecl_pix_if pif();

  logic hit;
  logic [7:0] tgt;
  logic [11:0] lo;
  logic [11:0] hi;
  logic signed [9:0] err;
  logic signed [17:0] pi_sum;
  logic signed [17:0] new_val;
  logic [31:0] rd_word;
  logic loop_run;

  ecl_pix_map u_map (
    .sys_clk(sys_clk),
    .rst(rst),
    .pif(pif)
  );

  assign pif.valid = pix_valid;
  assign pif.sample = pix_sample;
  assign pif.lut_on = lut_enable;
  assign pif.gamma_on = gamma_enable;
  assign pif.wr_en = lut_wr;
  assign pif.wr_addr = lut_wr_addr;
  assign pif.wr_data = lut_wr_data;
  assign pix_out_valid = pif.out_valid;
  assign pix_out = pif.pixel;

  assign hit = reg_addr == ECL_EXPO_OFFS;

  always_comb begin
    // out-of-range targets are pulled to the nearest bound
    if (target_level < ECL_TGT_MIN) begin
      tgt = ECL_TGT_MIN;
    end else if (target_level > ECL_TGT_MAX) begin
      tgt = ECL_TGT_MAX;
    end else begin
      tgt = target_level;
    end
    lo = limit_use ? limit_min : ECL_VAL_MIN_DEF;
    hi = limit_use ? limit_max : ECL_VAL_MAX_DEF;
    if (interlaced_mode1) begin
      lo = std_b ? FIELD_STEPS_B : FIELD_STEPS_A;
    end
    if (hi < lo) begin
      hi = lo;
    end
  end

  always_comb begin
    // positive error (too dark) lengthens exposure
    err = $signed({2'b00, tgt}) - $signed({2'b00, frame_mean});
    pi_sum = (18'(err) <<< ECL_KP_SHIFT) +
      (18'($signed(st_r.integ)) >>> ECL_KI_SHIFT);
    new_val = $signed({6'h00, st_r.expo}) + pi_sum;
  end

  always_comb begin
    rd_word = '0;
    rd_word[ECL_PRES_BIT] = 1'b1;
    rd_word[ECL_ABS_BIT] = st_r.abs_sel;
    rd_word[ECL_ONCE_BIT] = st_r.once_busy;
    rd_word[ECL_ENA_BIT] = st_r.enable;
    rd_word[ECL_AUTO_BIT] = st_r.auto_mode;
    rd_word[ECL_VAL_W-1:0] = st_r.value;
  end

  assign loop_run = st_r.enable && (st_r.auto_mode || st_r.once_busy);

  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = reg_wr || reg_rd;
    st_nxt.rdata = (reg_rd && hit) ? rd_word : 32'h00000000;
    if (reg_wr && hit) begin
      st_nxt.abs_sel = reg_wdata[ECL_ABS_BIT];
      st_nxt.enable = reg_wdata[ECL_ENA_BIT];
      st_nxt.auto_mode = reg_wdata[ECL_AUTO_BIT];
      if (st_r.enable && !st_r.auto_mode) begin
        st_nxt.value = reg_wdata[ECL_VAL_W-1:0];
      end
      // auto mode means the loop is already running
      if (reg_wdata[ECL_ONCE_BIT] && !st_r.auto_mode &&
          !reg_wdata[ECL_AUTO_BIT]) begin
        st_nxt.once_busy = 1'b1;
        st_nxt.once_cnt = ECL_ONCE_FRAMES;
        st_nxt.integ = '0;
      end
    end
    if (loop_run && frame_done) begin
      st_nxt.integ = 16'(st_r.integ + 16'($signed(err)));
      if (new_val < $signed({6'h00, lo})) begin
        st_nxt.expo = lo;
      end else if (new_val > $signed({6'h00, hi})) begin
        st_nxt.expo = hi;
      end else begin
        st_nxt.expo = new_val[11:0];
      end
      if (st_r.once_busy) begin
        st_nxt.once_cnt = st_r.once_cnt - 8'h01;
        if (st_r.once_cnt == 8'h01 || err == 10'sd0) begin
          st_nxt.once_busy = 1'b0;
          st_nxt.value = st_nxt.expo;
        end
      end
    end else if (!loop_run) begin
      st_nxt.integ = '0;
      if (st_r.abs_sel) begin
        st_nxt.expo = abs_value;
      end else begin
        st_nxt.expo = st_r.value;
      end
      if (st_nxt.expo < lo) begin
        st_nxt.expo = lo;
      end
    end
    if (!st_r.enable) begin
      st_nxt.once_busy = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.enable <= 1'b1;
      st_r.value <= ECL_VAL_RST;
      st_r.expo <= ECL_VAL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign reg_ack = st_r.ack;
  assign exposure_time = st_r.expo;
endmodule

// ### rtl/ecl_pkg.sv
package ecl_pkg;
  // exposure register; bit numbers count from the lsb, so IIDC bit 0 (the msb of the word) is bit 31 here
  localparam logic [31:0] ECL_EXPO_OFFS = 32'hf0f0081c;
  localparam int ECL_PRES_BIT = 31;
  localparam int ECL_ABS_BIT = 30;
  localparam int ECL_ONCE_BIT = 26;
  localparam int ECL_ENA_BIT = 25;
  localparam int ECL_AUTO_BIT = 24;
  localparam int ECL_VAL_W = 12;
  localparam logic [11:0] ECL_VAL_RST = 12'h100;
  localparam logic [11:0] ECL_VAL_MIN_DEF = 12'h001;
  localparam logic [11:0] ECL_VAL_MAX_DEF = 12'hfff;
  // target brightness limits
  localparam logic [7:0] ECL_TGT_MIN = 8'h32;
  localparam logic [7:0] ECL_TGT_MAX = 8'hcd;
  localparam logic [7:0] ECL_TGT_RST = 8'h80;
  // field periods in ms for the two video standards
  localparam int ECL_FIELD_MS_A = 33;
  localparam int ECL_FIELD_MS_B = 25;
  localparam logic [11:0] ECL_US_PER_STEP = 12'h00a;
  localparam int ECL_LUT_DEPTH = 1024;
  localparam int ECL_PIX_IN_W = 10;
  localparam int ECL_PIX_OUT_W = 8;
  localparam logic [3:0] ECL_KP_SHIFT = 4'h2;
  localparam logic [3:0] ECL_KI_SHIFT = 4'h4;
  localparam logic [7:0] ECL_ONCE_FRAMES = 8'h10;
endpackage

// ### rtl/ecl_pix_if.sv
interface ecl_pix_if;
  import ecl_pkg::*;
  logic valid;
  logic [ECL_PIX_IN_W-1:0] sample;
  logic out_valid;
  logic [ECL_PIX_OUT_W-1:0] pixel;
  logic lut_on;
  logic gamma_on;
  logic wr_en;
  logic [ECL_PIX_IN_W-1:0] wr_addr;
  logic [ECL_PIX_OUT_W-1:0] wr_data;
  modport ctrl(output valid, sample, lut_on, gamma_on, wr_en, wr_addr,
    wr_data, input out_valid, pixel);
  modport map(input valid, sample, lut_on, gamma_on, wr_en, wr_addr,
    wr_data, output out_valid, pixel);
endinterface

// ### rtl/ecl_pix_map.sv
module ecl_pix_map
  import ecl_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // pixel path
  ecl_pix_if.map pif
);
  typedef struct packed {
    logic out_valid;
    logic [ECL_PIX_OUT_W-1:0] pixel;
  } ecl_map_st_t;

  ecl_map_st_t st_r;
  ecl_map_st_t st_nxt;
  // volatile table: no initial contents, lost on power loss
  logic [ECL_PIX_OUT_W-1:0] lut_mem [ECL_LUT_DEPTH];

  // integer square root of a 10-bit value scaled to 8 bits:
  // sqrt(x*64) == 256*sqrt(x/1024)
  function automatic logic [7:0] ecl_gamma(input logic [9:0] x);
    logic [15:0] v;
    logic [7:0] r;
    v = {x, 6'h00};
    r = 8'h00;
    for (int b = 7; b >= 0; b--) begin
      if ({8'h00, r | 8'(1 << b)} * {8'h00, r | 8'(1 << b)} <= 16'(v)) begin
        r = r | 8'(1 << b);
      end
    end
    return r;
  endfunction

  always_ff @(posedge sys_clk) begin
    if (pif.wr_en) begin
      lut_mem[pif.wr_addr] <= pif.wr_data;
    end
  end

  always_comb begin
    st_nxt.out_valid = pif.valid;
    if (pif.gamma_on) begin
      st_nxt.pixel = ecl_gamma(pif.sample);
    end else if (pif.lut_on) begin
      st_nxt.pixel = lut_mem[pif.sample];
    end else begin
      st_nxt.pixel = pif.sample[ECL_PIX_IN_W-1 -: ECL_PIX_OUT_W];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pif.out_valid = st_r.out_valid;
  assign pif.pixel = st_r.pixel;
endmodule

// ### test/ecl_expo_lut_chk.sv
module ecl_expo_lut_chk
  import ecl_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register bus
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_ack,
  // pixel path
  input wire logic lut_enable,
  input wire logic gamma_enable,
  input wire logic pix_valid,
  input wire logic [9:0] pix_sample,
  input wire logic pix_out_valid,
  input wire logic [7:0] pix_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic hit;
  logic req;
  assign hit = reg_addr == ECL_EXPO_OFFS;
  assign req = reg_wr || reg_rd;
  ack_after_req_a: assert property (req |=> reg_ack)
    else $error("request not acknowledged");
  ack_only_req_a: assert property (reg_ack |-> $past(req))
    else $error("ack without request");
  present_bit_a: assert property (reg_rd && hit |=> reg_rdata[31])
    else $error("presence bit low");
  reserved_zero_a: assert property (reg_ack |-> reg_rdata[29:27] == 3'h0
    && reg_rdata[23:12] == 12'h000) else $error("reserved bits set");
  miss_zero_a: assert property (reg_rd && !hit |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  pix_follow_a: assert property (pix_valid |=> pix_out_valid)
    else $error("pixel missing");
  bypass_a: assert property (pix_valid && !lut_enable && !gamma_enable
    |=> pix_out == $past(pix_sample[9:2])) else $error("bypass wrong");
  gamma_top_a: assert property (pix_valid && gamma_enable
    && pix_sample == 10'h3ff |=> pix_out == 8'hff) else $error("gamma top");
  cover property (reg_rd && hit);
  cover property (pix_valid && gamma_enable && lut_enable);
  cover property (pix_valid && lut_enable && !gamma_enable);
endmodule

// ### test/ecl_host.sv
module ecl_host (
  // clock and answer
  input wire logic sys_clk,
  input wire logic reg_ack,
  // requests
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  output logic [31:0] reg_addr = 32'h0,
  output logic [31:0] reg_wdata = 32'h0,
  output logic lut_wr = 1'b0,
  output logic [9:0] lut_wr_addr = 10'h0,
  output logic [7:0] lut_wr_data = 8'h0,
  output logic lut_enable = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  function automatic logic [7:0] tbl(logic [9:0] a);
    return a[9:2] ^ 8'h5a;
  endfunction
  // one-cycle pulse; released lines show the inverse, not a stale value
  task automatic acc(logic w, logic [31:0] a, logic [31:0] d);
    int n = 0;
    @(posedge sys_clk) #1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(posedge sys_clk) #1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
    while (reg_ack !== 1'b1 && n < 8) begin
      @(posedge sys_clk);
      n++;
    end
  endtask
  // whole table goes in before the lookup is switched on
  task automatic load();
    for (int i = 0; i < 1024; i++) begin
      @(posedge sys_clk) #1;
      {lut_wr, lut_wr_addr, lut_wr_data} = {1'b1, i[9:0], tbl(i[9:0])};
    end
    @(posedge sys_clk) #1;
    {lut_wr, lut_wr_data, lut_enable} = {1'b0, ~lut_wr_data, 1'b1};
  endtask
endmodule

// ### test/ecl_expo_lut_tb.sv
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errors++; \
  $display("wrong value t=%0t %h %h", $time, a, e); end end
module ecl_expo_lut_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ecl_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr, reg_rd, reg_ack, lut_wr, lut_enable, pix_out_valid;
  logic [31:0] reg_addr, reg_wdata, reg_rdata;
  logic [9:0] lut_wr_addr, s;
  logic [7:0] lut_wr_data, pix_out;
  logic [11:0] exposure_time, old;
  logic [31:0] rexp;
  logic [7:0] pexp;
  logic [11:0] abs_value = 12'h0aa;
  logic [11:0] limit_min = 12'h001;
  logic [11:0] limit_max = 12'hfff;
  logic [7:0] target_level = 8'h80;
  logic [7:0] frame_mean = 8'h00;
  logic limit_use = 1'b0;
  logic interlaced_mode1 = 1'b0;
  logic std_b = 1'b0;
  logic gamma_enable = 1'b0;
  logic pix_valid = 1'b0;
  logic [9:0] pix_sample = 10'h0;
  logic frame_done = 1'b0;
  int errors, compares, cyc;
  logic [31:0] rq[$];
  logic [7:0] pq[$];
  ecl_expo_lut i_dut(.*);
  ecl_host i_host(.*);
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (reg_ack === 1'b1) begin
      rexp = rq.pop_front();
      `CHK(reg_rdata, rexp)
    end
    if (pix_out_valid === 1'b1) begin
      pexp = pq.pop_front();
      `CHK(pix_out, pexp)
    end
    cyc++;
    if (cyc > 4000) begin
      errors++;
      close_out();
    end
  end
  task automatic close_out();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic acc(logic w, logic [31:0] d, logic [31:0] e);
    rq.push_back(e);
    i_host.acc(w, ECL_EXPO_OFFS, d);
  endtask
  task automatic pix(logic [9:0] v, logic [7:0] e);
    @(posedge sys_clk) #1;
    {pix_valid, pix_sample} = {1'b1, v};
    pq.push_back(e);
  endtask
  task automatic endp();
    @(posedge sys_clk) #1;
    {pix_valid, pix_sample} = {1'b0, ~pix_sample};
    $display("pixel group done");
  endtask
  initial begin
    void'($urandom(39));
    repeat (4) @(posedge sys_clk);
    #1 rst = 1'b0;
    acc(1'b0, 32'h0, 32'h8200_0100);
    rq.push_back(32'h0);
    i_host.acc(1'b0, 32'h0, 32'h0);
    acc(1'b1, 32'h3a0f_f234, 32'h0);
    acc(1'b0, 32'h0, 32'h8200_0234);
    `CHK(exposure_time, 12'h234)
    acc(1'b1, 32'h0000_0345, 32'h0);
    acc(1'b1, 32'h0000_0111, 32'h0);
    acc(1'b0, 32'h0, 32'h8000_0345);
    acc(1'b1, 32'h0700_0222, 32'h0);
    acc(1'b0, 32'h0, 32'h8300_0345);
    $display("register test done");
    old = exposure_time;
    @(posedge sys_clk) #1;
    {frame_done, target_level} = {1'b1, 8'($urandom_range(205, 128))};
    @(posedge sys_clk) #1 frame_done = 1'b0;
    repeat (3) @(posedge sys_clk);
    `CHK(exposure_time > old, 1'b1)
    abs_value = 12'($urandom_range(4095, 16));
    acc(1'b1, 32'h4200_0345, 32'h0);
    @(posedge sys_clk) #1;
    `CHK(exposure_time, abs_value)
    {abs_value, interlaced_mode1} = {12'h010, 1'b1};
    repeat (2) @(posedge sys_clk) #1;
    `CHK(exposure_time, 12'hce4)
    std_b = 1'b1;
    repeat (2) @(posedge sys_clk) #1;
    `CHK(exposure_time, 12'h9c4)
    {interlaced_mode1, std_b} = 2'b00;
    {target_level, frame_mean} = {8'hff, 8'hcd};
    repeat (2) @(posedge sys_clk) #1;
    `CHK(exposure_time, 12'h010)
    acc(1'b1, 32'h4600_0345, 32'h0);
    acc(1'b0, 32'h0, 32'hc600_0345);
    @(posedge sys_clk) #1 frame_done = 1'b1;
    @(posedge sys_clk) #1 frame_done = 1'b0;
    acc(1'b0, 32'h0, 32'hc200_0010);
    $display("exposure test done");
    repeat (8) begin
      s = 10'($urandom);
      pix(s, s[9:2]);
    end
    endp();
    i_host.load();
    repeat (8) begin
      s = 10'($urandom);
      pix(s, i_host.tbl(s));
    end
    endp();
    gamma_enable = 1'b1;
    pix(10'h000, 8'h00);
    pix(10'h3ff, 8'hff);
    pix(10'h040, 8'h40);
    endp();
    repeat (3) @(posedge sys_clk);
    close_out();
  end
endmodule
bind ecl_expo_lut ecl_expo_lut_chk i_chk(.*);
